// *** design/tapc_regs.vh ***
// Register map and field layout of the touch result and pin config bank
`ifndef TAPC_REGS_VH
`define TAPC_REGS_VH

// Read addresses, 5-bit
`define TAPC_RD_VPOS      5'h10
`define TAPC_RD_HPOS      5'h11
`define TAPC_RD_PRESS_B   5'h12
`define TAPC_RD_SPARE_1   5'h13
`define TAPC_RD_SPARE_2   5'h14
`define TAPC_RD_SPARE_3   5'h15
`define TAPC_RD_BATT_1    5'h16
`define TAPC_RD_BATT_2    5'h17
`define TAPC_RD_THERM_SE  5'h18
`define TAPC_RD_THERM_DF  5'h19
`define TAPC_RD_PRESS_A   5'h1a
`define TAPC_RD_PCFG_A    5'h1b
`define TAPC_RD_PCFG_B    5'h1c

// Result block: base address and number of result words
`define TAPC_RES_BASE_MSB 1'h1
`define TAPC_RES_LAST     4'ha
`define TAPC_NUM_RES      11

// Write word: 4-bit address field, extended prefix and targets
`define TAPC_WR_EXT       4'hf
`define TAPC_EXT_PCFG_A   4'h0
`define TAPC_EXT_PCFG_B   4'h1
`define TAPC_EXT_SEL_HI   11
`define TAPC_EXT_SEL_LO   8
`define TAPC_EXT_VAL_HI   7

// Reset values
`define TAPC_RES_RST      12'h000
`define TAPC_PCFG_RST     8'h00
`define TAPC_RDATA_RST    12'h000

// Pin config pair A fields
`define TAPC_A_P2_IRQ_EN  0
`define TAPC_A_P2_DIR     1
`define TAPC_A_P2_POL     2
`define TAPC_A_P2_FSEL    3
`define TAPC_A_P1_IRQ_EN  4
`define TAPC_A_P1_DIR     5
`define TAPC_A_P1_POL     6
`define TAPC_A_P1_FSEL    7

// Pin config pair B fields
`define TAPC_B_P4_IRQ_EN  0

// Number of general pins handled here
`define TAPC_NUM_PINS     3

`endif

// *** design/tapc_sync2.v ***
// Two-stage synchroniser for the general pin inputs
`timescale 1ns/1ps
module tapc_sync2 #(
  parameter WIDTH = 3
) (
  // Clock and reset
  input  wire             i_clock,
  input  wire             i_nrst,
  // Asynchronous levels in, synchronised levels out
  input  wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // First stage is read only by the second stage
  always @(posedge i_clock) begin
    if (!i_nrst) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule // tapc_sync2

// *** design/tapc_pin_sense.v ***
// Per-pin direction, polarity and alert source decode
`timescale 1ns/1ps
module tapc_pin_sense (
  // Synchronised pad level
  input  wire i_pad,
  // Configuration fields
  input  wire i_fsel,
  input  wire i_dir,
  input  wire i_pol,
  input  wire i_irq_en,
  // Decoded results
  output wire o_alert_src,
  output wire o_oe_n,
  output wire o_out
);

  wire active;

  // Polarity 1 is active high, 0 active low
  assign active      = i_pol ? i_pad : ~i_pad;
  // Analog use of the shared terminal masks the pin out
  assign o_alert_src = i_fsel & i_irq_en & active;
  // Direction 0 drives, 1 listens; enable low while driving
  assign o_oe_n      = ~(i_fsel & ~i_dir);
  // No data register here, so a driven pin rests inactive
  assign o_out       = ~i_pol;

endmodule // tapc_pin_sense

// *** design/tapc_regbank.v ***
// Conversion result and general pin configuration register bank
//
// Behaviour
// - Vertical position result, read-only at 10000, resets to 0x000.
// - Horizontal position result, read-only at 10001.
// - Second pressure result, read-only at 10010.
// - First pressure result, read-only at 11010.
// - Spare input results one to three at 10011, 10100, 10101.
// - Battery input results one and two at 10110, 10111.
// - Single-ended thermal result, read-only at 11000.
// - Differential thermal result, read-only at 11001.
// - Write word with address field 1111b enters the extended map.
// - Next four bits pick the target, last eight are the value.
// - Pair A written at extended 0000, read at 11011, reset 0x000.
// - Pair B written at extended 0001, read at 11100, reset 0x000.
// - Pair A bits 4 and 0 enable pins one and two as alert sources.
// - Pair B bit 0 enables pin four as an alert source.
// - Direction bits 5 and 1: 0 output, 1 input.
// - Polarity bits 6 and 2: 0 active low, 1 active high.
// - Function bits 7 and 3: 0 spare analog, 1 general pin.
`timescale 1ns/1ps
`include "tapc_regs.vh"
module tapc_regbank (
  // Clock and reset
  input  wire        i_clock,
  input  wire        i_nrst,

  // Register port
  input  wire [4:0]  i_addr,
  input  wire [11:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [11:0] o_rdata,
  output reg         o_rvalid,

  // Conversion results from the sequencer
  input  wire        i_conv_valid,
  input  wire [3:0]  i_conv_chan,
  input  wire [11:0] i_conv_data,

  // General pin one
  input  wire        i_general_pin_one,
  output reg         o_general_pin_one,
  output reg         o_general_pin_one_oe_n,

  // General pin two
  input  wire        i_general_pin_two,
  output reg         o_general_pin_two,
  output reg         o_general_pin_two_oe_n,

  // General pin four
  input  wire        i_general_pin_four,
  output reg         o_general_pin_four,
  output reg         o_general_pin_four_oe_n,

  // Configuration view for the converter side
  output reg         o_pin_one_function_select,
  output reg         o_pin_two_function_select,

  // Alert output
  output reg         o_alert
);

  // Pin index inside the vector
  localparam P1 = 0;
  localparam P2 = 1;
  localparam P4 = 2;

  // Result storage, indexed by read address low nibble
  reg [11:0] result_q [0:`TAPC_NUM_RES-1];

  // Pin configuration registers
  reg [7:0]  pin_config_pair_a_q;
  reg [7:0]  pin_config_pair_b_q;
  reg [7:0]  pin_config_pair_a_d;
  reg [7:0]  pin_config_pair_b_d;

  // Read path
  reg [11:0] rdata_d;

  // Write decode
  wire       ext_write;
  wire [3:0] ext_sel;
  wire [7:0] ext_val;

  // Pin vectors
  wire [`TAPC_NUM_PINS-1:0] pad_async;
  wire [`TAPC_NUM_PINS-1:0] pad_sync;
  wire [`TAPC_NUM_PINS-1:0] pin_fsel;
  wire [`TAPC_NUM_PINS-1:0] pin_dir;
  wire [`TAPC_NUM_PINS-1:0] pin_pol;
  wire [`TAPC_NUM_PINS-1:0] pin_irq_en;
  wire [`TAPC_NUM_PINS-1:0] pin_alert_src;
  wire [`TAPC_NUM_PINS-1:0] pin_oe_n;
  wire [`TAPC_NUM_PINS-1:0] pin_out;

  wire       alert_d;

  // Result slot decode, used by the read path only
  function is_result_slot;
    input [3:0] slot;
    begin
      is_result_slot = (slot <= `TAPC_RES_LAST);
    end
  endfunction

  // Read address decode into one 12-bit word
  // Result word comes in as an argument so the read path sees updates
  function [11:0] read_word;
    input [4:0]  addr;
    input [11:0] res_word;
    input [7:0]  cfg_a;
    input [7:0] cfg_b;
    begin
      read_word = `TAPC_RDATA_RST;
      case (addr)
        `TAPC_RD_PCFG_A: begin
          read_word = {4'h0, cfg_a};
        end
        `TAPC_RD_PCFG_B: begin
          read_word = {4'h0, cfg_b};
        end
        default: begin
          if ((addr[4] == `TAPC_RES_BASE_MSB) &&
              is_result_slot(addr[3:0])) begin
            read_word = res_word;
          end
        end
      endcase
    end
  endfunction

  // Result registers: one slot per channel code 0 to 10
  genvar gi;
  generate
    for (gi = 0; gi < `TAPC_NUM_RES; gi = gi + 1) begin : g_result
      localparam [3:0] SLOT = gi;
      // No host write reaches these slots
      always @(posedge i_clock) begin
        if (!i_nrst) begin
          result_q[gi] <= `TAPC_RES_RST;
        end else if (i_conv_valid && (i_conv_chan == SLOT)) begin
          result_q[gi] <= i_conv_data;
        end
      end
    end
  endgenerate

  // Extended write word: prefix, target select, 8-bit value
  assign ext_write = i_wr && (i_addr[3:0] == `TAPC_WR_EXT);
  assign ext_sel   = i_wdata[`TAPC_EXT_SEL_HI:`TAPC_EXT_SEL_LO];
  assign ext_val   = i_wdata[`TAPC_EXT_VAL_HI:0];

  // Other write addresses belong to other banks and are ignored here
  always @* begin
    pin_config_pair_a_d = pin_config_pair_a_q;
    pin_config_pair_b_d = pin_config_pair_b_q;
    if (ext_write) begin
      case (ext_sel)
        `TAPC_EXT_PCFG_A: begin
          pin_config_pair_a_d = ext_val;
        end
        `TAPC_EXT_PCFG_B: begin
          pin_config_pair_b_d = ext_val;
        end
        default: begin
          pin_config_pair_a_d = pin_config_pair_a_q;
        end
      endcase
    end
  end

  always @(posedge i_clock) begin
    if (!i_nrst) begin
      pin_config_pair_a_q <= `TAPC_PCFG_RST;
      pin_config_pair_b_q <= `TAPC_PCFG_RST;
    end else begin
      pin_config_pair_a_q <= pin_config_pair_a_d;
      pin_config_pair_b_q <= pin_config_pair_b_d;
    end
  end

  // Read data stand for one cycle only, zero otherwise
  always @* begin
    rdata_d = `TAPC_RDATA_RST;
    if (i_rd) begin
      rdata_d = read_word(i_addr, result_q[i_addr[3:0]],
                          pin_config_pair_a_q, pin_config_pair_b_q);
    end
  end

  always @(posedge i_clock) begin
    if (!i_nrst) begin
      o_rdata  <= `TAPC_RDATA_RST;
      o_rvalid <= 1'b0;
    end else begin
      o_rdata  <= rdata_d;
      o_rvalid <= i_rd;
    end
  end

  // Pads are asynchronous to the register clock
  assign pad_async[P1] = i_general_pin_one;
  assign pad_async[P2] = i_general_pin_two;
  assign pad_async[P4] = i_general_pin_four;

  tapc_sync2 #(
    .WIDTH (`TAPC_NUM_PINS)
  ) u_pad_sync (
    .i_clock (i_clock),
    .i_nrst  (i_nrst),
    .i_async (pad_async),
    .o_sync  (pad_sync)
  );

  // Field extraction for pins one and two
  assign pin_fsel[P1]   = pin_config_pair_a_q[`TAPC_A_P1_FSEL];
  assign pin_fsel[P2]   = pin_config_pair_a_q[`TAPC_A_P2_FSEL];
  assign pin_dir[P1]    = pin_config_pair_a_q[`TAPC_A_P1_DIR];
  assign pin_dir[P2]    = pin_config_pair_a_q[`TAPC_A_P2_DIR];
  assign pin_pol[P1]    = pin_config_pair_a_q[`TAPC_A_P1_POL];
  assign pin_pol[P2]    = pin_config_pair_a_q[`TAPC_A_P2_POL];
  assign pin_irq_en[P1] = pin_config_pair_a_q[`TAPC_A_P1_IRQ_EN];
  assign pin_irq_en[P2] = pin_config_pair_a_q[`TAPC_A_P2_IRQ_EN];

  // Pin four: dedicated input, active high, only its enable is mapped
  assign pin_fsel[P4]   = 1'b1;
  assign pin_dir[P4]    = 1'b1;
  assign pin_pol[P4]    = 1'b1;
  assign pin_irq_en[P4] = pin_config_pair_b_q[`TAPC_B_P4_IRQ_EN];

  generate
    for (gi = 0; gi < `TAPC_NUM_PINS; gi = gi + 1) begin : g_pin
      tapc_pin_sense u_sense (
        .i_pad       (pad_sync[gi]),
        .i_fsel      (pin_fsel[gi]),
        .i_dir       (pin_dir[gi]),
        .i_pol       (pin_pol[gi]),
        .i_irq_en    (pin_irq_en[gi]),
        .o_alert_src (pin_alert_src[gi]),
        .o_oe_n      (pin_oe_n[gi]),
        .o_out       (pin_out[gi])
      );
    end
  endgenerate

  // Level alert, not latched: it follows the sources
  assign alert_d = |pin_alert_src;

  // All pin outputs registered; enables start released
  always @(posedge i_clock) begin
    if (!i_nrst) begin
      o_general_pin_one         <= 1'b0;
      o_general_pin_one_oe_n    <= 1'b1;
      o_general_pin_two         <= 1'b0;
      o_general_pin_two_oe_n    <= 1'b1;
      o_general_pin_four        <= 1'b0;
      o_general_pin_four_oe_n   <= 1'b1;
      o_pin_one_function_select <= 1'b0;
      o_pin_two_function_select <= 1'b0;
      o_alert                   <= 1'b0;
    end else begin
      o_general_pin_one         <= pin_out[P1];
      o_general_pin_one_oe_n    <= pin_oe_n[P1];
      o_general_pin_two         <= pin_out[P2];
      o_general_pin_two_oe_n    <= pin_oe_n[P2];
      o_general_pin_four        <= pin_out[P4];
      o_general_pin_four_oe_n   <= pin_oe_n[P4];
      o_pin_one_function_select <= pin_fsel[P1];
      o_pin_two_function_select <= pin_fsel[P2];
      o_alert                   <= alert_d;
    end
  end

endmodule // tapc_regbank

// *** test/tapc_regbank_chk.sv ***
// Port assertions for the result and pin config bank
`timescale 1ns/1ps
module tapc_regbank_chk (
  // Clock and reset
  input wire        i_clock,
  input wire        i_nrst,
  // Register port
  input wire [4:0]  i_addr,
  input wire [11:0] i_wdata,
  input wire        i_wr,
  input wire        i_rd,
  input wire [11:0] o_rdata,
  input wire        o_rvalid,
  // Conversion port
  input wire        i_conv_valid,
  input wire [3:0]  i_conv_chan,
  input wire [11:0] i_conv_data,
  // Pin view
  input wire        o_general_pin_one_oe_n,
  input wire        o_general_pin_two_oe_n,
  input wire        o_pin_one_function_select,
  input wire        o_pin_two_function_select
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  AST_RD_ANSWER: assert property (i_rd |=> o_rvalid)
    else $error("read strobe not answered");
  AST_RD_QUIET: assert property (!i_rd |=> !o_rvalid && o_rdata == 12'h000)
    else $error("read data outside answer cycle");
  AST_UNMAPPED: assert property (i_rd && !i_addr[4] |=> o_rdata == 12'h000)
    else $error("unmapped read not zero");
  AST_SLOT_ZERO: assert property ((i_conv_valid && i_conv_chan == 4'h0) ##1
    (i_rd && i_addr == 5'h10) |=> o_rdata == $past(i_conv_data, 2))
    else $error("vertical result not returned");
  AST_SLOT_ANY: assert property ((i_conv_valid && i_conv_chan < 4'hb) ##1
    (i_rd && i_addr == {1'b1, $past(i_conv_chan)})
    |=> o_rdata == $past(i_conv_data, 2))
    else $error("result slot not returned");
  AST_FSEL: assert property ((i_wr && i_addr[3:0] == 4'hf
    && i_wdata[11:8] == 4'h0) ##1 !i_wr |=>
    o_pin_one_function_select == $past(i_wdata[7], 2) &&
    o_pin_two_function_select == $past(i_wdata[3], 2))
    else $error("function select not following pair A");
  AST_OE1_GATED: assert property (!o_pin_one_function_select
    |-> o_general_pin_one_oe_n) else $error("pin one driven while analog");
  AST_OE2_GATED: assert property (!o_pin_two_function_select
    |-> o_general_pin_two_oe_n) else $error("pin two driven while analog");
endmodule // tapc_regbank_chk

bind tapc_regbank tapc_regbank_chk u_chk (
  .i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
  .i_conv_valid(i_conv_valid), .i_conv_chan(i_conv_chan),
  .i_conv_data(i_conv_data),
  .o_general_pin_one_oe_n(o_general_pin_one_oe_n),
  .o_general_pin_two_oe_n(o_general_pin_two_oe_n),
  .o_pin_one_function_select(o_pin_one_function_select),
  .o_pin_two_function_select(o_pin_two_function_select));

// *** test/tapc_host_model.sv ***
// Host side master of the register port
`timescale 1ns/1ps
module tapc_host_model (
  // Clock
  input  wire         i_clock,
  // Read answer
  input  wire  [11:0] i_rdata,
  input  wire         i_rvalid,
  // Request
  output logic [4:0]  o_addr,
  output logic [11:0] o_wdata,
  output logic        o_wr,
  output logic        o_rd
);
  initial begin
    o_addr = 5'h00;
    o_wdata = 12'h000;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // Released lines show the inverse so stale values never pass
  task automatic wr(input logic [4:0] a, input logic [11:0] d);
    @(posedge i_clock);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clock);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  task automatic rd(input logic [4:0] a, output logic [11:0] d,
                    output logic v);
    @(posedge i_clock);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clock);
    o_rd <= 1'b0;
    o_addr <= ~a;
    #1;
    d = i_rdata;
    v = i_rvalid;
  endtask
endmodule // tapc_host_model

// *** test/tapc_regbank_tb_top.sv ***
// Self-checking bench of the result and pin config bank
`timescale 1ns/1ps
module tapc_regbank_tb_top;
  logic        clk, nrst, cv, p1, p2, p4, rv, wr, rd, v;
  logic [3:0]  ch;
  logic [4:0]  addr;
  logic [11:0] cd, wd, rdat, d;
  logic [7:0]  cfg_a, cfg_b;
  logic [31:0] r;
  logic [11:0] res [0:10];
  logic        po1, po2, po4, oe1, oe2, oe4, fs1, fs2, alert;
  int          miscompares, samples_checked, cyc;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  tapc_host_model u_tapc_host_model (.i_clock(clk), .i_rdata(rdat),
    .i_rvalid(rv), .o_addr(addr), .o_wdata(wd), .o_wr(wr), .o_rd(rd));
  tapc_regbank u_tapc_regbank (.i_clock(clk), .i_nrst(nrst), .i_addr(addr),
    .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .o_rvalid(rv),
    .i_conv_valid(cv), .i_conv_chan(ch), .i_conv_data(cd),
    .i_general_pin_one(p1), .o_general_pin_one(po1),
    .o_general_pin_one_oe_n(oe1), .i_general_pin_two(p2),
    .o_general_pin_two(po2), .o_general_pin_two_oe_n(oe2),
    .i_general_pin_four(p4), .o_general_pin_four(po4),
    .o_general_pin_four_oe_n(oe4), .o_pin_one_function_select(fs1),
    .o_pin_two_function_select(fs2), .o_alert(alert));

  task automatic chk(input string n, input logic [11:0] e,
                     input logic [11:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [11:0] exp_rd(input logic [4:0] a);
    if (a >= 5'h10 && a <= 5'h1a) return res[a[3:0]];
    if (a == 5'h1b) return {4'h0, cfg_a};
    if (a == 5'h1c) return {4'h0, cfg_b};
    return 12'h000;
  endfunction
  task automatic rdchk(input logic [4:0] a);
    u_tapc_host_model.rd(a, d, v);
    chk("rvalid", 12'h001, {11'h000, v});
    chk($sformatf("read %h", a), exp_rd(a), d);
  endtask
  task automatic conv(input logic [3:0] c, input logic [11:0] x);
    @(posedge clk);
    cv <= 1'b1;
    ch <= c;
    cd <= x;
    @(posedge clk);
    cv <= 1'b0;
    ch <= ~c;
    cd <= ~x;
    if (c < 4'hb) res[c] = x;
  endtask
  task automatic ext(input logic [3:0] s, input logic [7:0] x);
    u_tapc_host_model.wr(5'h0f, {s, x});
    if (s == 4'h0) cfg_a = x;
    if (s == 4'h1) cfg_b = x;
  endtask
  // Pads settle through two sync flops and the output flop
  task automatic alert_case(input logic [7:0] a, input logic [7:0] b,
                            input logic [2:0] pads, input logic e);
    ext(4'h0, a);
    ext(4'h1, b);
    {p4, p2, p1} <= pads;
    repeat (5) @(posedge clk);
    #1;
    chk("alert", {11'h000, e}, {11'h000, alert});
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      stop_test;
    end
  end

  initial begin
    {nrst, cv, ch, cd, p1, p2, p4, cfg_a, cfg_b} = '0;
    foreach (res[i]) res[i] = 12'h000;
    void'($urandom(32'h4918));
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    for (int a = 0; a < 32; a++) rdchk(a[4:0]);
    repeat (80) begin
      r = $urandom;
      case (r[1:0])
        2'd0: rdchk(r[8:4]);
        2'd1: conv(r[7:4], r[19:8]);
        2'd2: ext({2'b00, r[5:4]}, r[13:6]);
        default: u_tapc_host_model.wr({r[8], 1'b0, r[6:4]}, r[20:9]);
      endcase
    end
    for (int a = 16; a < 29; a++) rdchk(a[4:0]);
    for (int k = 0; k < 8; k++) begin
      ext(4'h0, {k[2], k[1], k[0], 1'b0, k[2], k[1], k[0], 1'b0});
      repeat (2) @(posedge clk);
      #1;
      chk("oe one", {11'h000, ~k[2] | k[0]}, {11'h000, oe1});
      chk("oe two", {11'h000, ~k[2] | k[0]}, {11'h000, oe2});
      chk("fsel one", {11'h000, k[2]}, {11'h000, fs1});
      chk("fsel two", {11'h000, k[2]}, {11'h000, fs2});
      chk("drive four", 12'h000, {11'h000, po4});
      if (k[2] && !k[0]) chk("drive", {11'h000, ~k[1]}, {11'h000, po2});
      if (k[2] && !k[0]) chk("drive one", {11'h000, ~k[1]}, {11'h000, po1});
    end
    alert_case(8'hf0, 8'h00, 3'b001, 1'b1);
    alert_case(8'he0, 8'h00, 3'b001, 1'b0);
    alert_case(8'hb0, 8'h00, 3'b000, 1'b1);
    alert_case(8'h70, 8'h00, 3'b001, 1'b0);
    alert_case(8'h0f, 8'h00, 3'b010, 1'b1);
    alert_case(8'h0f, 8'h00, 3'b000, 1'b0);
    alert_case(8'h00, 8'h01, 3'b100, 1'b1);
    alert_case(8'h00, 8'h00, 3'b100, 1'b0);
    chk("oe four", 12'h001, {11'h000, oe4});
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    {cfg_a, cfg_b} = '0;
    foreach (res[i]) res[i] = 12'h000;
    for (int a = 16; a < 29; a++) rdchk(a[4:0]);
    stop_test;
  end
endmodule // tapc_regbank_tb_top
